// ===== tb/dgram_sink.sv
// Serial sender stand-in that reports the end of each datagram
`timescale 1ns/10ps
module dgram_sink (
  input  wire logic       core_clk_i,
  input  wire logic       tx_start_i,
  input  wire logic [3:0] dly_i,
  output wire logic       tx_done_o
);
  logic [3:0] left_reg = 4'h0;
  logic       done_reg = 1'b0;
  assign tx_done_o = done_reg;
  always @(posedge core_clk_i) begin
    done_reg <= (left_reg == 4'h1);
    if (tx_start_i) left_reg <= dly_i;
    else if (left_reg != 4'h0) left_reg <= left_reg - 4'h1;
  end
endmodule // dgram_sink

// ===== tb/test_tx_ctrl.sv
// Testbench for the reset and trigger transmit control block
`timescale 1ns/10ps
module test_tx_ctrl;
  import trig_ctrl_pkg::*;
  localparam int PER = 20;
  logic core_clk_i = 0, srst_i = 1, rst_n = 1, trig_n = 1, trig_mode = 0, bias_en = 1, sreq = 0;
  logic ce = 1;
  logic tick, start, init, strobe, done, seen;
  logic [KIND_W-1:0] skind = '0, kind, got;
  logic [3:0] dly = 4'h2;
  int err_total = 0, n_checks = 0, cyc = 0;
  always #5 core_clk_i = ~core_clk_i;
  tx_ctrl #(.SAMPLE_PERIOD(PER)) i_tx_ctrl (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce),
    .reset_in_low_i(rst_n), .tx_trigger_in_i(trig_n), .trig_mode_i(trig_mode),
    .bias_trim_en_i(bias_en), .special_req_i(sreq), .special_kind_i(skind), .tx_done_i(done),
    .sample_tick_o(tick), .tx_start_o(start), .tx_kind_o(kind), .init_mode_o(init),
    .sample_valid_strobe_o(strobe));
  dgram_sink i_dgram_sink (.core_clk_i(core_clk_i), .tx_start_i(start), .dly_i(dly),
    .tx_done_o(done));
  task chk(string what, logic [KIND_W-1:0] e, logic [KIND_W-1:0] g);
    n_checks++;
    if (e !== g) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task wait_start(int lim);
    seen = 0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(negedge core_clk_i);
      if (start === 1'b1) begin
        seen = 1;
        got = kind;
      end
    end
  endtask
  task init_seq(int n);
    for (int k = 1; k <= n; k++) begin
      wait_start(60);
      chk("init kind", KIND_W'(k), seen ? got : 'x);
    end
    repeat (10) @(negedge core_clk_i);
    chk("init mode", 0, init);
  endtask
  task t_free();
    dly <= 4'hc;
    wait_start(PER + 5);
    chk("free kind", KIND_SENSOR, seen ? got : 'x);
    chk("tick with start", 1, tick);
    chk("strobe busy", 0, strobe);
    repeat (15) @(negedge core_clk_i);
    chk("strobe done", 1, strobe);
  endtask
  task t_hold();
    @(posedge core_clk_i);
    ce <= 0;
    wait_start(2 * PER);
    chk("frozen start", 0, seen);
    chk("frozen tick", 0, tick);
    @(posedge core_clk_i);
    ce <= 1;
    wait_start(PER + 5);
    chk("resume kind", KIND_SENSOR, seen ? got : 'x);
  endtask
  task t_trig();
    @(posedge core_clk_i);
    trig_mode <= 1;
    dly <= 4'h2;
    wait_start(3 * PER);
    chk("idle pin", 0, seen);
    @(posedge core_clk_i);
    sreq <= 1;
    skind <= KIND_SERIAL;
    @(posedge core_clk_i);
    skind <= KIND_CONFIG;
    @(posedge core_clk_i);
    sreq <= 0;
    trig_n <= 0;
    wait_start(20);
    chk("special kind", KIND_CONFIG, seen ? got : 'x);
    wait_start(30);
    chk("one per edge", 0, seen);
    @(posedge core_clk_i);
    trig_n <= 1;
    repeat (20) @(posedge core_clk_i);
    trig_n <= 0;
    wait_start(20);
    chk("trig kind", KIND_SENSOR, seen ? got : 'x);
    @(posedge core_clk_i);
    trig_n <= 1;
  endtask
  task t_pin();
    repeat (20) @(posedge core_clk_i);
    bias_en <= 0;
    rst_n <= 0;
    repeat (10) @(negedge core_clk_i);
    chk("pin reset", 1, init);
    @(posedge core_clk_i);
    rst_n <= 1;
    init_seq(3);
  endtask
  task end_of_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Run should end well before this ceiling
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    srst_i <= 0;
    init_seq(4);
    t_free();
    t_hold();
    t_trig();
    t_pin();
    end_of_test();
  end
endmodule // test_tx_ctrl

// ===== tb/tx_ctrl_chk.sv
// Port checker for the transmit control block
`timescale 1ns/10ps
module tx_ctrl_chk
  import trig_ctrl_pkg::*;
#(
  parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
  input wire logic              core_clk_i,
  input wire logic              srst_i,
  input wire logic              ce_i,
  input wire logic              reset_in_low_i,
  input wire logic              tx_trigger_in_i,
  input wire logic              trig_mode_i,
  input wire logic              bias_trim_en_i,
  input wire logic              tx_done_i,
  input wire logic              sample_tick_o,
  input wire logic              tx_start_o,
  input wire logic [KIND_W-1:0] tx_kind_o,
  input wire logic              init_mode_o,
  input wire logic              sample_valid_strobe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Slack covers the pin reset synchroniser tail
  int gap_reg;
  // A frozen clock enable stretches the tick gap, so hold the count
  always_ff @(posedge core_clk_i)
    gap_reg <= (srst_i || !reset_in_low_i || sample_tick_o) ? 0 :
               ce_i ? gap_reg + 1 : gap_reg;
  AST_START_PULSE: assert property (tx_start_o |=> !tx_start_o)
    else $error("start pulse too long");
  AST_TICK_DUE: assert property (gap_reg <= SAMPLE_PERIOD + 8)
    else $error("sample tick late");
  AST_STROBE_FALL: assert property ($fell(sample_valid_strobe_o) |-> sample_tick_o)
    else $error("strobe fell off tick");
  AST_STROBE_RISE: assert property (
    $rose(sample_valid_strobe_o) && !init_mode_o |-> $past(tx_done_i))
    else $error("strobe rose without done");
  AST_INIT_FIRST: assert property (
    $fell(srst_i) && reset_in_low_i |-> ##[1:2] (tx_start_o && tx_kind_o == KIND_PART))
    else $error("no first init datagram");
  AST_INIT_ORDER: assert property (
    init_mode_o && tx_done_i && tx_kind_o == KIND_PART
    |-> ##[1:3] (tx_start_o && tx_kind_o == KIND_SERIAL))
    else $error("init order wrong");
  AST_INIT_EXIT: assert property (
    init_mode_o && tx_done_i && tx_kind_o == (bias_trim_en_i ? KIND_BIASTRIM : KIND_CONFIG)
    |-> ##[1:2] !init_mode_o)
    else $error("init mode not left");
  AST_TRIG_ONLY: assert property (
    tx_start_o && !init_mode_o && trig_mode_i && $past(trig_mode_i) && $past(trig_mode_i, 2)
    |-> !$past(tx_trigger_in_i, 3))
    else $error("start without trigger");
endmodule // tx_ctrl_chk
bind tx_ctrl tx_ctrl_chk #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) i_tx_ctrl_chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .reset_in_low_i(reset_in_low_i),
  .tx_trigger_in_i(tx_trigger_in_i), .trig_mode_i(trig_mode_i), .bias_trim_en_i(bias_trim_en_i),
  .tx_done_i(tx_done_i), .sample_tick_o(sample_tick_o), .tx_start_o(tx_start_o),
  .tx_kind_o(tx_kind_o), .init_mode_o(init_mode_o), .sample_valid_strobe_o(sample_valid_strobe_o));

// ===== verilog/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync
  import trig_ctrl_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output logic      level_o
);
  // ==========================================================================
  // Stages
  // ==========================================================================
  logic [SYNC_STAGES-1:0] stage_reg;
  // Level only moves once the last two stages agree
  wire agree = (stage_reg[1] == stage_reg[2]);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      stage_reg <= {SYNC_STAGES{RESET_LEVEL}};
      level_o   <= RESET_LEVEL;
    end else if (ce_i) begin
      stage_reg <= {stage_reg[SYNC_STAGES-2:0], pin_i};
      if (agree) begin
        level_o <= stage_reg[2];
      end
    end
  end
endmodule // pin_sync

// ===== verilog/trig_ctrl_pkg.sv
// Constants for the reset and trigger transmit control block
package trig_ctrl_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ          = 100_000_000;
  localparam int SAMPLE_RATE_SPS = 2000;
  localparam int SAMPLE_CYCLES   = CLK_HZ / SAMPLE_RATE_SPS;
  localparam int SAMPLE_CNT_W    = $clog2(SAMPLE_CYCLES);
  // ==========================================================================
  // Datagram selection and synchroniser depth
  // ==========================================================================
  localparam int INIT_DGRAM_CNT  = 3;
  localparam int KIND_W          = 3;
  localparam logic [KIND_W-1:0] KIND_SENSOR   = 3'h0;
  localparam logic [KIND_W-1:0] KIND_PART     = 3'h1;
  localparam logic [KIND_W-1:0] KIND_SERIAL   = 3'h2;
  localparam logic [KIND_W-1:0] KIND_CONFIG   = 3'h3;
  localparam logic [KIND_W-1:0] KIND_BIASTRIM = 3'h4;
  localparam int SYNC_STAGES     = 3;
endpackage

// ===== verilog/tx_ctrl.sv
// Reset, init sequence and trigger-driven transmit control
// Behaviour
// RULE1: Reset pin is active low; unconnected input reads high, deasserted.
// RULE2: Reset pin low restarts controller into initialisation mode.
// RULE3: Without trigger mode, transmissions start automatically after power-on.
// RULE4: Trigger pin only starts transmissions in triggered mode.
// RULE5: Sampling keeps running at 2000 samples per second always; the code stops the timer while ce_i or the reset pin is low.
// RULE6: Each trigger falling edge sends exactly one latest-sample datagram; the code drops edges that arrive in ST_BUSY or in init mode.
// RULE7: Trigger pin idles high; unconnected input makes no edge.
// RULE8: Pending special request replaces sensor datagram at next trigger.
// RULE9: Several special requests before trigger: only the last is kept.
// RULE10: Init mode sends 3 special datagrams without waiting for trigger.
// RULE11: After init datagrams, plus optional bias trim, enter normal mode.
// RULE12: Valid strobe falls with sample tick, rises after datagram ends.
// RULE13: Trigger and reset pins pass a synchroniser before use.
`timescale 1ns/10ps
module tx_ctrl
  import trig_ctrl_pkg::*;
#(
  parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
  input  wire logic              core_clk_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  input  wire logic              reset_in_low_i,
  input  wire logic              tx_trigger_in_i,
  input  wire logic              trig_mode_i,
  input  wire logic              bias_trim_en_i,
  input  wire logic              special_req_i,
  input  wire logic [KIND_W-1:0] special_kind_i,
  input  wire logic              tx_done_i,
  output logic                   sample_tick_o,
  output logic                   tx_start_o,
  output logic [KIND_W-1:0]      tx_kind_o,
  output logic                   init_mode_o,
  output logic                   sample_valid_strobe_o
);
  typedef enum logic [1:0] {ST_INIT, ST_INIT_WAIT, ST_IDLE, ST_BUSY} state_e;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic in_init(input state_e st);
    return (st == ST_INIT) || (st == ST_INIT_WAIT);
  endfunction

  // Trim datagram adds one index past the fixed init set
  function automatic logic [1:0] last_init(input logic with_trim);
    return with_trim ? 2'(INIT_DGRAM_CNT) : 2'(INIT_DGRAM_CNT - 1);
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic rst_lvl;
  logic trig_lvl;
  logic trig_lvl_reg;

  // RULE13 Sync reset pin
  // RULE1 Idle high reset
  pin_sync #(.RESET_LEVEL(1'b1)) u_rst_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .pin_i      (reset_in_low_i),
    .level_o    (rst_lvl)
  );

  // RULE13 Sync trigger pin
  // RULE7 Idle high trigger
  pin_sync #(.RESET_LEVEL(1'b1)) u_trig_sync (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .pin_i      (tx_trigger_in_i),
    .level_o    (trig_lvl)
  );

  // ==========================================================================
  // Decode
  // ==========================================================================
  state_e                  state_reg;
  logic [SAMPLE_CNT_W-1:0] samp_cnt_reg;
  logic [1:0]              init_idx_reg;
  logic                    pend_reg;
  logic [KIND_W-1:0]       pend_kind_reg;

  // RULE2 Pin reset restarts
  wire soft_rst   = srst_i | ~rst_lvl;
  // RULE6 Falling edge detect
  wire trig_fall  = trig_lvl_reg & ~trig_lvl;
  // RULE5 Free-running sample tick
  wire samp_wrap  = (samp_cnt_reg == SAMPLE_CNT_W'(SAMPLE_PERIOD - 1));
  // RULE4 Trigger gated by mode
  // RULE3 Free-run sends per sample
  wire send_req   = trig_mode_i ? trig_fall : samp_wrap;
  // RULE11 Optional bias trim
  wire [1:0] init_last = last_init(bias_trim_en_i);
  wire [KIND_W-1:0] init_kind = KIND_W'(init_idx_reg) + KIND_PART;
  // RULE8 Special replaces sensor
  wire [KIND_W-1:0] send_kind = pend_reg ? pend_kind_reg : KIND_SENSOR;

  // ==========================================================================
  // Sample timer and trigger history
  // ==========================================================================
  always_ff @(posedge core_clk_i) begin
    if (soft_rst) begin
      samp_cnt_reg  <= '0;
      sample_tick_o <= 1'b0;
    end else if (ce_i) begin
      samp_cnt_reg  <= samp_wrap ? '0 : samp_cnt_reg + 1'b1;
      sample_tick_o <= samp_wrap;
    end
  end

  // Idle-high history, so no false edge right after reset
  always_ff @(posedge core_clk_i) begin
    if (soft_rst) begin
      trig_lvl_reg <= 1'b1;
    end else if (ce_i) begin
      trig_lvl_reg <= trig_lvl;
    end
  end

  // ==========================================================================
  // Special request latch
  // ==========================================================================
  always_ff @(posedge core_clk_i) begin
    if (soft_rst) begin
      pend_reg      <= 1'b0;
      pend_kind_reg <= KIND_SENSOR;
    end else if (ce_i) begin
      // RULE9 Last request wins
      if (special_req_i && !in_init(state_reg)) begin
        pend_reg      <= 1'b1;
        pend_kind_reg <= special_kind_i;
      end else if (state_reg == ST_IDLE && send_req) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Sequencer next state
  // ==========================================================================
  state_e            state_next;
  logic [1:0]        init_idx_next;
  logic              start_next;
  logic [KIND_W-1:0] kind_next;
  logic              strobe_next;

  always_comb begin
    state_next    = state_reg;
    init_idx_next = init_idx_reg;
    start_next    = 1'b0;
    kind_next     = tx_kind_o;
    strobe_next   = sample_valid_strobe_o;
    case (state_reg)
      // RULE10 Init ignores trigger
      ST_INIT: begin
        start_next = 1'b1;
        kind_next  = init_kind;
        state_next = ST_INIT_WAIT;
      end
      ST_INIT_WAIT: begin
        // RULE11 Advance to normal
        if (tx_done_i && init_idx_reg == init_last) begin
          state_next = ST_IDLE;
        end else if (tx_done_i) begin
          init_idx_next = init_idx_reg + 2'h1;
          state_next    = ST_INIT;
        end
      end
      ST_IDLE: begin
        if (send_req) begin
          start_next = 1'b1;
          kind_next  = send_kind;
          state_next = ST_BUSY;
        end
        // RULE12 Strobe falls on tick
        if (samp_wrap) begin
          strobe_next = 1'b0;
        end
      end
      ST_BUSY: begin
        // RULE12 Rise after last bit
        if (tx_done_i) begin
          strobe_next = 1'b1;
          state_next  = ST_IDLE;
        end else if (samp_wrap) begin
          strobe_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_INIT;
      end
    endcase
  end

  // ==========================================================================
  // Sequencer registers
  // ==========================================================================
  always_ff @(posedge core_clk_i) begin
    if (soft_rst) begin
      state_reg    <= ST_INIT;
      init_idx_reg <= 2'h0;
    end else if (ce_i) begin
      state_reg    <= state_next;
      init_idx_reg <= init_idx_next;
    end
  end

  // Outputs straight from flops, so the host sees no decode glitches
  always_ff @(posedge core_clk_i) begin
    if (soft_rst) begin
      tx_start_o            <= 1'b0;
      tx_kind_o             <= KIND_SENSOR;
      init_mode_o           <= 1'b1;
      sample_valid_strobe_o <= 1'b1;
    end else if (ce_i) begin
      tx_start_o            <= start_next;
      tx_kind_o             <= kind_next;
      init_mode_o           <= in_init(state_next);
      sample_valid_strobe_o <= strobe_next;
    end
  end
endmodule // tx_ctrl
